// ---- include/pmu_ctrl_defines.vh ----
// register offsets, field positions, reset values and timing for the power mode controller
// included by the controller design file; holds definitions only
`ifndef PMU_CTRL_DEFINES_VH
`define PMU_CTRL_DEFINES_VH

// register offsets in the processor's page-0 register space
`define ANALOG_REGULATOR_CTRL_ADDR 8'h48
`define DIGITAL_REGULATOR_CTRL_ADDR 8'h49
`define BATTERY_EOL_CTRL_ADDR 8'h4a

// analog_regulator_ctrl fields
`define ANALOG_DEFAULT_TUNING_BIT 5
`define ANALOG_REGULATOR_ON_BIT 4
`define ANALOG_TRIM_MSB 3
`define ANALOG_TRIM_LSB 0
`define ANALOG_DEFAULT_TUNING_RST 1'b1
`define ANALOG_REGULATOR_ON_RST 1'b0
`define ANALOG_TRIM_RST 4'h3

// digital_regulator_ctrl fields
`define WAKE_LEVEL_BIT 7
`define DIGITAL_STATE_BIT 4
`define DIGITAL_TRIM_MSB 3
`define DIGITAL_TRIM_LSB 2
`define DIGITAL_HOLD_BIT 1
`define DIGITAL_TRIM_RST 2'h0
`define DIGITAL_HOLD_RST 1'b1

// battery_eol_ctrl fields
`define BATTERY_ABOVE_BIT 7
`define BATTERY_DETECTOR_ON_BIT 5
`define BATTERY_CODE_MSB 4
`define BATTERY_CODE_LSB 0
`define BATTERY_DETECTOR_ON_RST 1'b0
`define BATTERY_CODE_RST 5'h00

// power modes
`define MODE_OFF 2'h0
`define MODE_ON 2'h1
`define MODE_AUDIO 2'h2

// timing: clock period in ns, detector start-up and response limits in us
`define SYS_CLK_PERIOD_NS 20
`define EOL_START_US 100
`define EOL_RESPONSE_US 20
// start-up is a least wait: rounded up
`define EOL_START_CYCLES ((`EOL_START_US * 1000 + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
// response is a longest time: rounded down
`define EOL_RESPONSE_CYCLES ((`EOL_RESPONSE_US * 1000) / `SYS_CLK_PERIOD_NS)

`endif

// ---- rtl/level_sync.v ----
// two flip-flop synchroniser for a single asynchronous level
// assumes one system clock and an asynchronous active-low reset
`timescale 1ns/1ps
module level_sync
#(
  parameter RESET_LEVEL = 1'b0
)
(
  // clock and reset
  input wire i_sys_clk,
  input wire i_rstn,
  // level in and out
  input wire i_async_level,
  output reg o_sync_level
);

  reg stage_one;

  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      stage_one <= RESET_LEVEL;
      o_sync_level <= RESET_LEVEL;
    end
    else
    begin
      stage_one <= i_async_level;
      o_sync_level <= stage_one;
    end
  end

endmodule

// ---- rtl/power_mode_eol_control.v ----
// power mode controller: regulator control registers, OFF/ON/AUDIO sequencing and
// battery end-of-life detector control and status.
// assumes the processor's 8-bit register port on the system clock; the wake pin and the
// analog comparator output are asynchronous and are synchronised here.
`timescale 1ns/1ps
`include "pmu_ctrl_defines.vh"
module power_mode_eol_control
#(
  parameter [3:0] ANALOG_DEFAULT_TRIM = 4'h3,
  parameter EOL_START_CYCLES = `EOL_START_CYCLES
)
(
  // clock and reset
  input wire i_sys_clk,
  input wire i_rstn,
  // processor register port
  input wire [7:0] i_reg_addr,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] i_reg_wdata,
  output reg [7:0] o_reg_rdata,
  // pins and analog comparator
  input wire i_wake_pin,
  input wire i_battery_comparator,
  // regulator controls
  output reg o_analog_supply_output_on,
  output reg [3:0] o_analog_regulator_trim,
  output reg o_digital_supply_output_on,
  output reg [1:0] o_digital_regulator_trim,
  // block power and detector controls
  output reg o_codec_power_on,
  output reg o_battery_detector_on,
  output reg [4:0] o_battery_threshold_code,
  output reg o_battery_status_valid,
  output reg [1:0] o_power_mode
);

  localparam CNT_W = 16;
  localparam integer START_LAST_INT = EOL_START_CYCLES - 1;
  localparam [CNT_W-1:0] START_LAST = START_LAST_INT[CNT_W-1:0];

  // control registers
  reg analog_default_tuning;
  reg analog_regulator_on;
  reg [3:0] analog_regulator_trim;
  reg [1:0] digital_regulator_trim;
  reg digital_regulator_hold;
  reg battery_detector_on;
  reg [4:0] battery_threshold_code;
  reg [1:0] mode;
  reg [CNT_W-1:0] start_count;
  reg start_done;

  // synchronised inputs and edge detect
  wire wake_level;
  wire battery_above_threshold;
  reg wake_last;
  wire wake_rise;

  reg [1:0] next_mode;
  reg [7:0] next_rdata;
  wire wr_analog;
  wire wr_digital;
  wire wr_eol;
  wire detector_powered;

  level_sync #(.RESET_LEVEL(1'b0)) u_wake_sync
  (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_async_level(i_wake_pin),
    .o_sync_level(wake_level)
  );

  // the two-flop delay is 40 ns, far inside the response limit
  level_sync #(.RESET_LEVEL(1'b0)) u_eol_sync
  (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_async_level(i_battery_comparator),
    .o_sync_level(battery_above_threshold)
  );

  assign wake_rise = wake_level & ~wake_last;
  // writes while OFF are dropped: the core would be unpowered
  assign wr_analog = i_reg_wr && (i_reg_addr == `ANALOG_REGULATOR_CTRL_ADDR) &&
    (mode != `MODE_OFF);
  assign wr_digital = i_reg_wr && (i_reg_addr == `DIGITAL_REGULATOR_CTRL_ADDR) &&
    (mode != `MODE_OFF);
  assign wr_eol = i_reg_wr && (i_reg_addr == `BATTERY_EOL_CTRL_ADDR) &&
    (mode != `MODE_OFF);
  assign detector_powered = battery_detector_on && (mode != `MODE_OFF);

  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      wake_last <= 1'b0;
    else
      wake_last <= wake_level;
  end

  // register writes
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      analog_default_tuning <= `ANALOG_DEFAULT_TUNING_RST;
      analog_regulator_on <= `ANALOG_REGULATOR_ON_RST;
      analog_regulator_trim <= `ANALOG_TRIM_RST;
      digital_regulator_trim <= `DIGITAL_TRIM_RST;
      digital_regulator_hold <= `DIGITAL_HOLD_RST;
      battery_detector_on <= `BATTERY_DETECTOR_ON_RST;
      battery_threshold_code <= `BATTERY_CODE_RST;
    end
    else
    begin
      if (wr_analog)
      begin
        analog_default_tuning <= i_reg_wdata[`ANALOG_DEFAULT_TUNING_BIT];
        analog_regulator_on <= i_reg_wdata[`ANALOG_REGULATOR_ON_BIT];
        analog_regulator_trim <= i_reg_wdata[`ANALOG_TRIM_MSB:`ANALOG_TRIM_LSB];
      end
      else if (mode == `MODE_OFF && wake_rise)
      begin
        // waking always lands in ON, so any stale audio request is dropped
        analog_regulator_on <= 1'b0;
      end
      if (wr_digital)
      begin
        digital_regulator_trim <= i_reg_wdata[`DIGITAL_TRIM_MSB:`DIGITAL_TRIM_LSB];
        digital_regulator_hold <= i_reg_wdata[`DIGITAL_HOLD_BIT];
      end
      else if (mode == `MODE_OFF && wake_rise)
      begin
        // rearm the hold so the new ON session is not shut at once
        digital_regulator_hold <= 1'b1;
      end
      if (wr_eol)
      begin
        battery_detector_on <= i_reg_wdata[`BATTERY_DETECTOR_ON_BIT];
        battery_threshold_code <= i_reg_wdata[`BATTERY_CODE_MSB:`BATTERY_CODE_LSB];
      end
    end
  end

  // power mode sequencing; shutdown outranks an audio request
  always @*
  begin
    next_mode = mode;
    case (mode)
      `MODE_OFF:
      begin
        if (wake_rise)
          next_mode = `MODE_ON;
      end
      `MODE_ON:
      begin
        if (!digital_regulator_hold)
          next_mode = `MODE_OFF;
        else if (analog_regulator_on)
          next_mode = `MODE_AUDIO;
      end
      `MODE_AUDIO:
      begin
        if (!digital_regulator_hold)
          next_mode = `MODE_OFF;
        else if (!analog_regulator_on)
          next_mode = `MODE_ON;
      end
      default:
        next_mode = `MODE_ON;
    endcase
  end

  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      mode <= `MODE_ON;
    else
      mode <= next_mode;
  end

  // detector start-up timer; restarts whenever the detector loses power
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      start_count <= {CNT_W{1'b0}};
      start_done <= 1'b0;
    end
    else if (!detector_powered)
    begin
      start_count <= {CNT_W{1'b0}};
      start_done <= 1'b0;
    end
    else if (!start_done)
    begin
      if (start_count == START_LAST)
        start_done <= 1'b1;
      else
        start_count <= start_count + 1'b1;
    end
  end

  // read mux; write-only and reserved bits read zero, unmapped addresses read zero
  always @*
  begin
    next_rdata = 8'h00;
    case (i_reg_addr)
      `ANALOG_REGULATOR_CTRL_ADDR:
      begin
        next_rdata[`ANALOG_DEFAULT_TUNING_BIT] = analog_default_tuning;
        next_rdata[`ANALOG_REGULATOR_ON_BIT] = analog_regulator_on;
        next_rdata[`ANALOG_TRIM_MSB:`ANALOG_TRIM_LSB] = analog_regulator_trim;
      end
      `DIGITAL_REGULATOR_CTRL_ADDR:
      begin
        next_rdata[`WAKE_LEVEL_BIT] = wake_level;
        next_rdata[`DIGITAL_STATE_BIT] = (mode != `MODE_OFF);
        next_rdata[`DIGITAL_TRIM_MSB:`DIGITAL_TRIM_LSB] = digital_regulator_trim;
      end
      `BATTERY_EOL_CTRL_ADDR:
      begin
        next_rdata[`BATTERY_ABOVE_BIT] = battery_above_threshold;
        next_rdata[`BATTERY_DETECTOR_ON_BIT] = battery_detector_on;
        next_rdata[`BATTERY_CODE_MSB:`BATTERY_CODE_LSB] = battery_threshold_code;
      end
      default:
        next_rdata = 8'h00;
    endcase
  end

  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
      o_reg_rdata <= next_rdata;
  end

  // registered outputs; mode, supplies, codec and detector enable are driven from the next mode so they change with it
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_power_mode <= `MODE_ON;
      o_digital_supply_output_on <= 1'b1;
      o_analog_supply_output_on <= 1'b0;
      o_codec_power_on <= 1'b0;
      o_analog_regulator_trim <= ANALOG_DEFAULT_TRIM;
      o_digital_regulator_trim <= `DIGITAL_TRIM_RST;
      o_battery_detector_on <= 1'b0;
      o_battery_threshold_code <= `BATTERY_CODE_RST;
      o_battery_status_valid <= 1'b0;
    end
    else
    begin
      o_power_mode <= next_mode;
      o_digital_supply_output_on <= (next_mode != `MODE_OFF);
      o_analog_supply_output_on <= (next_mode == `MODE_AUDIO);
      o_codec_power_on <= (next_mode == `MODE_AUDIO);
      o_analog_regulator_trim <= analog_default_tuning ? ANALOG_DEFAULT_TRIM :
        analog_regulator_trim;
      o_digital_regulator_trim <= digital_regulator_trim;
      o_battery_detector_on <= battery_detector_on && (next_mode != `MODE_OFF);
      o_battery_threshold_code <= battery_threshold_code;
      o_battery_status_valid <= start_done && detector_powered;
    end
  end

endmodule

// ---- test/power_mode_eol_control_sva.sv ----
// assertions on the ports of the power mode controller
// assumes one system clock and the design's asynchronous active-low reset
`timescale 1ns/1ps
module power_mode_eol_control_sva
#(
  parameter EOL_START_CYCLES = 5000
)
(
  // clock, reset and register port
  input wire i_sys_clk,
  input wire i_rstn,
  input wire [7:0] i_reg_addr,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] i_reg_wdata,
  input wire [7:0] o_reg_rdata,
  // pins and controls
  input wire i_wake_pin,
  input wire i_battery_comparator,
  input wire o_analog_supply_output_on,
  input wire [3:0] o_analog_regulator_trim,
  input wire o_digital_supply_output_on,
  input wire [1:0] o_digital_regulator_trim,
  input wire o_codec_power_on,
  input wire o_battery_detector_on,
  input wire [4:0] o_battery_threshold_code,
  input wire o_battery_status_valid,
  input wire [1:0] o_power_mode
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  wire in_off = (o_power_mode == 2'h0);
  wire wr_eol = i_reg_wr && i_reg_addr == 8'h4a;
  // last byte written to the detector register, so later cycles can compare against it
  reg [7:0] eol_q;
  always @(posedge i_sys_clk or negedge i_rstn)
    if (!i_rstn)
      eol_q <= 8'h00;
    else if (wr_eol)
      eol_q <= i_reg_wdata;
  chk_audio_powers: assert property (
    o_power_mode == 2'h2 |-> o_analog_supply_output_on && o_digital_supply_output_on
      && o_codec_power_on) else $error("audio mode not fully powered");
  chk_on_powers: assert property (
    o_power_mode == 2'h1 |-> o_digital_supply_output_on && !o_analog_supply_output_on
      && !o_codec_power_on) else $error("on mode supplies wrong");
  chk_off_powers: assert property (
    in_off |-> !(o_digital_supply_output_on || o_analog_supply_output_on || o_codec_power_on
      || o_battery_detector_on)) else $error("supply left on in off mode");
  chk_hold_drop: assert property (
    i_reg_wr && i_reg_addr == 8'h49 && !i_reg_wdata[1] && !in_off |-> ##[1:3] in_off)
    else $error("hold cleared but not off");
  // a hold clear one cycle earlier still shows ON here but wins over the request
  chk_audio_request: assert property (
    i_reg_wr && i_reg_addr == 8'h48 && i_reg_wdata[4] && o_power_mode == 2'h1
      && !($past(i_reg_wr) && $past(i_reg_addr) == 8'h49 && !$past(i_reg_wdata[1]))
      |-> ##[1:3] o_power_mode == 2'h2) else $error("audio request ignored");
  chk_on_leave: assert property (
    o_power_mode == 2'h1 ##1 o_power_mode != 2'h1 |-> $past(i_reg_wr, 2) || $past(i_reg_wr, 3))
    else $error("on mode left without a write");
  chk_state_read: assert property (
    i_reg_rd && i_reg_addr == 8'h49 |=> o_reg_rdata[4] == ($past(o_power_mode) != 2'h0))
    else $error("regulator state bit wrong");
  chk_wake_hold: assert property (
    in_off && !i_wake_pin && !$past(i_wake_pin) && !$past(i_wake_pin, 2) && !$past(i_wake_pin, 3)
      |=> in_off) else $error("off mode left without wake");
  chk_code_follow: assert property (
    wr_eol && !in_off |-> ##[1:3] o_battery_threshold_code == eol_q[4:0])
    else $error("threshold code not applied");
  chk_detector_follow: assert property (
    wr_eol && !in_off |-> ##[1:3] o_battery_detector_on == eol_q[5])
    else $error("detector enable not applied");
  // cycles the detector has been powered, saturating so it never wraps
  reg [15:0] det_cycles;
  always @(posedge i_sys_clk or negedge i_rstn)
    if (!i_rstn)
      det_cycles <= 16'h0000;
    else if (!o_battery_detector_on)
      det_cycles <= 16'h0000;
    else if (det_cycles != 16'hffff)
      det_cycles <= det_cycles + 16'h0001;
  chk_valid_wait: assert property (
    o_battery_status_valid |-> det_cycles >= EOL_START_CYCLES)
    else $error("status valid before start-up elapsed");
  cover property (o_power_mode == 2'h2);
  cover property (in_off ##1 o_power_mode == 2'h1);
  cover property (o_battery_status_valid);
endmodule
bind power_mode_eol_control power_mode_eol_control_sva #(.EOL_START_CYCLES(EOL_START_CYCLES))
  chk_u (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .i_wake_pin(i_wake_pin), .i_battery_comparator(i_battery_comparator),
  .o_analog_supply_output_on(o_analog_supply_output_on),
  .o_analog_regulator_trim(o_analog_regulator_trim),
  .o_digital_supply_output_on(o_digital_supply_output_on),
  .o_digital_regulator_trim(o_digital_regulator_trim), .o_codec_power_on(o_codec_power_on),
  .o_battery_detector_on(o_battery_detector_on),
  .o_battery_threshold_code(o_battery_threshold_code),
  .o_battery_status_valid(o_battery_status_valid), .o_power_mode(o_power_mode));

// ---- test/tb.sv ----
// self-checking bench for the power mode controller
// drives register port and pins directly; detector start-up shortened to 8 cycles
`timescale 1ns/1ps
module tb;
  reg i_sys_clk = 1'b0;
  reg i_rstn = 1'b0;
  reg [7:0] i_reg_addr = 8'h00;
  reg i_reg_wr = 1'b0;
  reg i_reg_rd = 1'b0;
  reg [7:0] i_reg_wdata = 8'h00;
  reg i_wake_pin = 1'b0;
  reg i_battery_comparator = 1'b0;
  wire [7:0] rdata;
  wire an, dg, cd, det, vld;
  wire [3:0] at;
  wire [1:0] dt, mode;
  wire [4:0] code;
  wire [7:0] pwr = {2'h0, det, cd, an, dg, mode};
  integer fail_count = 0;
  integer checks = 0;
  integer i;
  always #10 i_sys_clk = ~i_sys_clk;
  power_mode_eol_control #(.EOL_START_CYCLES(8)) dut_u (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(rdata), .i_wake_pin(i_wake_pin), .i_battery_comparator(i_battery_comparator),
    .o_analog_supply_output_on(an), .o_analog_regulator_trim(at),
    .o_digital_supply_output_on(dg), .o_digital_regulator_trim(dt), .o_codec_power_on(cd),
    .o_battery_detector_on(det), .o_battery_threshold_code(code),
    .o_battery_status_valid(vld), .o_power_mode(mode));
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
  begin
    checks = checks + 1;
    if (got !== exp)
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      fail_count = fail_count + 1;
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  end
  endtask
  task rd(input [7:0] a, input [7:0] m, input [7:0] e);
  begin
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    @(posedge i_sys_clk);
    #1;
    chk(rdata & m, e);
  end
  endtask
  // pins are asynchronous: give the synchronisers time before anything reads them
  task pins(input w, input c);
  begin
    @(posedge i_sys_clk);
    i_wake_pin <= w;
    i_battery_comparator <= c;
    repeat (4) @(posedge i_sys_clk);
    #1;
  end
  endtask
  task wait_mode(input [1:0] m, input [7:0] e);
  begin
    for (i = 0; i < 12 && mode !== m; i = i + 1)
    begin
      @(posedge i_sys_clk);
      #1;
    end
    #1;
    chk(pwr, e);
    if (i == 12)
      end_sim;
  end
  endtask
  initial
  begin
    repeat (16) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    @(posedge i_sys_clk);
    #1;
    chk(pwr, 8'h05);
    chk({4'h0, at}, 8'h03);
    rd(8'h48, 8'hff, 8'h23);
    rd(8'h49, 8'h7f, 8'h10);
    rd(8'h4a, 8'h7f, 8'h00);
    rd(8'h4b, 8'hff, 8'h00);
    $display("test reset done");
    wr(8'h48, 8'h0a);
    wr(8'h49, 8'h0e);
    pins(1'b1, 1'b1);
    chk({4'h0, at}, 8'h0a);
    chk({6'h0, dt}, 8'h03);
    rd(8'h49, 8'hff, 8'h9c);
    rd(8'h4a, 8'h80, 8'h80);
    wr(8'h48, 8'h2a);
    pins(1'b0, 1'b0);
    chk({4'h0, at}, 8'h03);
    rd(8'h49, 8'h80, 8'h00);
    rd(8'h4a, 8'h80, 8'h00);
    $display("test trims and pins done");
    wr(8'h48, 8'h1a);
    wait_mode(2'h2, 8'h1e);
    wr(8'h48, 8'h0a);
    wait_mode(2'h1, 8'h05);
    $display("test audio done");
    wr(8'h4a, 8'h3f);
    rd(8'h4a, 8'h7f, 8'h3f);
    chk({2'h0, det, code}, 8'h3f);
    chk({7'h0, vld}, 8'h00);
    for (i = 0; i < 20 && vld !== 1'b1; i = i + 1)
    begin
      @(posedge i_sys_clk);
      #1;
    end
    #1;
    chk({7'h0, vld}, 8'h01);
    if (i == 20)
      end_sim;
    $display("test detector done");
    wr(8'h48, 8'h1a);
    wait_mode(2'h2, 8'h3e);
    wr(8'h49, 8'h00);
    wait_mode(2'h0, 8'h00);
    // this write lands in OFF and must be dropped: trim and default bit stay as before
    wr(8'h48, 8'h3a);
    pins(1'b0, 1'b0);
    chk(pwr, 8'h00);
    rd(8'h49, 8'h10, 8'h00);
    pins(1'b1, 1'b0);
    wait_mode(2'h1, 8'h25);
    rd(8'h48, 8'h3f, 8'h0a);
    rd(8'h49, 8'h10, 8'h10);
    $display("test shutdown and wake done");
    end_sim;
  end
endmodule
